// ==== rfs_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts for the
//          reference fail status and mask block
// Assumes: 16-bit host register port, one clock
// Notes:   included by bare name; definitions only
`ifndef RFS_CONSTS_SVH
`define RFS_CONSTS_SVH

`define RFS_WORD_W           16
`define RFS_ADDR_W           16
`define RFS_NUM_REFS         4
`define RFS_GROUP_W          4

`define RFS_ADDR_STATUS      16'h0069
`define RFS_ADDR_MASK        16'h006A
`define RFS_MASK_RESET       16'h0000
`define RFS_STATUS_RESET     16'h0000
`define RFS_RDATA_RESET      16'h0000
`define RFS_UNMAPPED_DATA    16'h0000

`define RFS_BIT_SINGLE_HIGH  0
`define RFS_BIT_SINGLE_LOW   1
`define RFS_BIT_MULTI_HIGH   2
`define RFS_BIT_MULTI_LOW    3
`define RFS_TIMING_REFERENCE_3_MULTI_HIGH  14

`define RFS_STATUS_LAG       1
`define RFS_ACK_LAG          1

`endif

// ==== rfs_pkg.sv ====
// Purpose: shared types of the reference fail status and mask block
// Assumes: constants live in rfs_consts.svh
// Notes:   nothing here is imported; use rfs_pkg::name
package rfs_pkg;

    typedef logic [15:0] rfs_word_t;

    typedef enum logic [1:0] {
        RFS_CHK_SINGLE_HIGH = 2'b00,
        RFS_CHK_SINGLE_LOW  = 2'b01,
        RFS_CHK_MULTI_HIGH  = 2'b10,
        RFS_CHK_MULTI_LOW   = 2'b11
    } rfs_check_e;

    typedef enum logic [1:0] {
        RFS_ACC_NONE  = 2'b00,
        RFS_ACC_READ  = 2'b01,
        RFS_ACC_WRITE = 2'b10
    } rfs_acc_e;

endpackage : rfs_pkg

// ==== rfs_ref_fail_status_mask.sv ====
// Purpose: reference fail status and check mask registers on the host port
// Assumes: host strobes and check results synchronous to sys_clk
// Notes:   one access per cycle; answer one cycle after the strobe
`include "rfs_consts.svh"

module rfs_ref_fail_status_mask (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire logic [`RFS_WORD_W-1:0] ref_check_fail,
    input  wire logic                   host_cs,
    input  wire logic                   host_wr,
    input  wire logic [`RFS_ADDR_W-1:0] host_addr,
    input  wire logic [`RFS_WORD_W-1:0] host_wdata,
    output logic      [`RFS_WORD_W-1:0] host_rdata_ff,
    output logic                        host_ack_ff,
    output logic                        host_err_ff,
    output logic      [`RFS_WORD_W-1:0] ref_fail_status_ff,
    output logic      [`RFS_WORD_W-1:0] ref_check_mask_ff
);

    // address match against one register
    function automatic logic addr_hit(
        input logic [`RFS_ADDR_W-1:0] addr,
        input logic [`RFS_ADDR_W-1:0] target
    );
        addr_hit = (addr == target);
    endfunction : addr_hit

    rfs_pkg::rfs_acc_e  acc;
    rfs_pkg::rfs_word_t nxt_check_mask;
    rfs_pkg::rfs_word_t nxt_rdata;
    logic               nxt_ack;
    logic               nxt_err;
    logic               hit_status;
    logic               hit_mask;

    // per-reference flag slices, four bits each
    genvar g;
    generate
        for (g = 0; g < `RFS_NUM_REFS; g++) begin : g_ref
            localparam int lsb = g * `RFS_GROUP_W;
            rfs_ref_slice u_slice (
                .sys_clk       (sys_clk),
                .arst_n        (arst_n),
                .check_fail    (ref_check_fail[lsb +: `RFS_GROUP_W]),
                .check_mask    (ref_check_mask_ff[lsb +: `RFS_GROUP_W]),
                .fail_flags_ff (ref_fail_status_ff[lsb +: `RFS_GROUP_W])
            );
        end
    endgenerate

    // access decode
    always_comb begin
        hit_status = addr_hit(host_addr, `RFS_ADDR_STATUS);
        hit_mask   = addr_hit(host_addr, `RFS_ADDR_MASK);
        if (!host_cs) begin
            acc = rfs_pkg::RFS_ACC_NONE;
        end else if (host_wr) begin
            acc = rfs_pkg::RFS_ACC_WRITE;
        end else begin
            acc = rfs_pkg::RFS_ACC_READ;
        end
    end

    // register file next values
    always_comb begin
        nxt_check_mask = ref_check_mask_ff;
        nxt_rdata      = host_rdata_ff;
        nxt_ack        = 1'b0;
        nxt_err        = 1'b0;
        case (acc)
            rfs_pkg::RFS_ACC_READ: begin
                nxt_ack = 1'b1;
                if (hit_status) begin
                    nxt_rdata = ref_fail_status_ff;
                end else if (hit_mask) begin
                    nxt_rdata = ref_check_mask_ff;
                end else begin
                    nxt_rdata = `RFS_UNMAPPED_DATA;
                    nxt_err   = 1'b1;
                end
            end
            rfs_pkg::RFS_ACC_WRITE: begin
                nxt_ack = 1'b1;
                if (hit_mask) begin
                    nxt_check_mask = host_wdata;
                end else begin
                    // write to status or an unmapped address dropped; flags stay with the checks
                    nxt_err = 1'b1;
                end
            end
            rfs_pkg::RFS_ACC_NONE: begin
                nxt_ack = 1'b0;
            end
            default: begin
                nxt_ack = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_check_mask_ff <= `RFS_MASK_RESET;
            host_rdata_ff     <= `RFS_RDATA_RESET;
            host_ack_ff       <= 1'b0;
            host_err_ff       <= 1'b0;
        end else begin
            ref_check_mask_ff <= nxt_check_mask;
            host_rdata_ff     <= nxt_rdata;
            host_ack_ff       <= nxt_ack;
            host_err_ff       <= nxt_err;
        end
    end

    // checks on the block
    default clocking cb_main @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    property p_timing_reference_0_multi_low;
        (ref_check_fail[`RFS_BIT_MULTI_LOW] && !ref_check_mask_ff[`RFS_BIT_MULTI_LOW])
            |=> ref_fail_status_ff[3];
    endproperty
    a_timing_reference_0_multi_low: assert property (p_timing_reference_0_multi_low)
        else $error("timing_reference_0 multi low fail not on bit 3");

    property p_timing_reference_0_multi_high;
        $past(arst_n) |-> ref_fail_status_ff[2] ==
            $past(ref_check_fail[`RFS_BIT_MULTI_HIGH] && !ref_check_mask_ff[`RFS_BIT_MULTI_HIGH]);
    endproperty
    a_timing_reference_0_multi_high: assert property (p_timing_reference_0_multi_high)
        else $error("timing_reference_0 multi high fail not on bit 2");

    sequence s_timing_reference_0_single_low_fail;
        ref_check_fail[`RFS_BIT_SINGLE_LOW] && !ref_check_mask_ff[`RFS_BIT_SINGLE_LOW];
    endsequence
    property p_timing_reference_0_single_low;
        s_timing_reference_0_single_low_fail [*2] |-> ref_fail_status_ff[1];
    endproperty
    a_timing_reference_0_single_low: assert property (p_timing_reference_0_single_low)
        else $error("timing_reference_0 single low fail not on bit 1");

    property p_timing_reference_0_single_high;
        ref_check_fail[`RFS_BIT_SINGLE_HIGH] && !ref_check_mask_ff[`RFS_BIT_SINGLE_HIGH]
            |=> ref_fail_status_ff[0];
    endproperty
    a_timing_reference_0_single_high: assert property (p_timing_reference_0_single_high)
        else $error("timing_reference_0 single high fail not on bit 0");

    property p_mask_forces_pass;
        (ref_fail_status_ff & $past(ref_check_mask_ff)) == '0;
    endproperty
    a_mask_forces_pass: assert property (p_mask_forces_pass)
        else $error("masked check shows a failure");

    property p_timing_reference_3_mask_group;
        (host_cs && host_wr && host_addr == `RFS_ADDR_MASK && host_wdata[15:12] == 4'hF)
            ##1 (ref_check_fail[15:12] == 4'hF) [*2] |-> ref_fail_status_ff[15:12] == 4'h0;
    endproperty
    a_timing_reference_3_mask_group: assert property (p_timing_reference_3_mask_group)
        else $error("timing_reference_3 mask bits do not gate timing_reference_3 flags");

    property p_timing_reference_2_mask_group;
        (host_cs && host_wr && host_addr == `RFS_ADDR_MASK)
            |=> ref_check_mask_ff[11:8] == $past(host_wdata[11:8]);
    endproperty
    a_timing_reference_2_mask_group: assert property (p_timing_reference_2_mask_group)
        else $error("timing_reference_2 mask bits not written");

    property p_timing_reference_1_mask_group;
        $past(arst_n) |-> ref_fail_status_ff[7:4] ==
            $past(ref_check_fail[7:4] & ~ref_check_mask_ff[7:4]);
    endproperty
    a_timing_reference_1_mask_group: assert property (p_timing_reference_1_mask_group)
        else $error("timing_reference_1 flags not gated by mask bits 7..4");

    property p_timing_reference_0_mask_group;
        (host_cs && host_wr && host_addr == `RFS_ADDR_MASK && host_wdata[3:0] == 4'hF)
            ##1 1'b1 [*1] |=> ref_fail_status_ff[3:0] == 4'h0;
    endproperty
    a_timing_reference_0_mask_group: assert property (p_timing_reference_0_mask_group)
        else $error("timing_reference_0 mask bits do not gate timing_reference_0 flags");

    property p_status_read_only;
        (host_cs && host_wr && host_addr == `RFS_ADDR_STATUS)
            |=> ref_check_mask_ff == $past(ref_check_mask_ff) && host_err_ff
                ##1 ref_fail_status_ff == $past(ref_check_fail & ~ref_check_mask_ff);
    endproperty
    a_status_read_only: assert property (p_status_read_only)
        else $error("status write changed block state");

    property p_timing_reference_3_multi_high_pos;
        $past(arst_n) |-> ref_fail_status_ff[`RFS_TIMING_REFERENCE_3_MULTI_HIGH] ==
            $past(ref_check_fail[`RFS_TIMING_REFERENCE_3_MULTI_HIGH] &&
                  !ref_check_mask_ff[`RFS_TIMING_REFERENCE_3_MULTI_HIGH]);
    endproperty
    a_timing_reference_3_multi_high_pos: assert property (p_timing_reference_3_multi_high_pos)
        else $error("timing_reference_3 multi high flag not at bit 14");

    property p_flag_follows_pass;
        (ref_check_fail == '0) |=> ref_fail_status_ff == '0;
    endproperty
    a_flag_follows_pass: assert property (p_flag_follows_pass)
        else $error("flag stayed high after check passed");

    property p_read_status_data;
        (host_cs && !host_wr && host_addr == `RFS_ADDR_STATUS)
            |=> host_ack_ff && !host_err_ff && host_rdata_ff == $past(ref_fail_status_ff);
    endproperty
    a_read_status_data: assert property (p_read_status_data)
        else $error("status read returned wrong data");

    property p_timing_reference_3_group;
        $past(arst_n) |-> ref_fail_status_ff[15:12] ==
            $past(ref_check_fail[15:12] & ~ref_check_mask_ff[15:12]);
    endproperty
    a_timing_reference_3_group: assert property (p_timing_reference_3_group)
        else $error("timing_reference_3 flags not gated by mask bits 15..12");

    property p_timing_reference_2_group;
        $past(arst_n) |-> ref_fail_status_ff[11:8] ==
            $past(ref_check_fail[11:8] & ~ref_check_mask_ff[11:8]);
    endproperty
    a_timing_reference_2_group: assert property (p_timing_reference_2_group)
        else $error("timing_reference_2 flags not gated by mask bits 11..8");

    property p_timing_reference_0_group;
        $past(arst_n) |-> ref_fail_status_ff[3:0] ==
            $past(ref_check_fail[3:0] & ~ref_check_mask_ff[3:0]);
    endproperty
    a_timing_reference_0_group: assert property (p_timing_reference_0_group)
        else $error("timing_reference_0 flags not gated by mask bits 3..0");

    property p_timing_reference_0_low_masked;
        ref_check_mask_ff[`RFS_BIT_SINGLE_LOW] |=> !ref_fail_status_ff[1];
    endproperty
    a_timing_reference_0_low_masked: assert property (p_timing_reference_0_low_masked)
        else $error("masked timing_reference_0 single low check reported a failure");

    property p_timing_reference_0_multi_low_clears;
        !ref_check_fail[`RFS_BIT_MULTI_LOW] |=> !ref_fail_status_ff[3];
    endproperty
    a_timing_reference_0_multi_low_clears: assert property (p_timing_reference_0_multi_low_clears)
        else $error("timing_reference_0 multi low flag stayed high after pass");

    property p_ack_after_access;
        host_cs |=> host_ack_ff;
    endproperty
    a_ack_after_access: assert property (p_ack_after_access)
        else $error("access not acknowledged one cycle later");

    property p_ack_only_after_access;
        !host_cs |=> !host_ack_ff;
    endproperty
    a_ack_only_after_access: assert property (p_ack_only_after_access)
        else $error("acknowledge without an access");

    property p_err_with_ack;
        host_err_ff |-> host_ack_ff;
    endproperty
    a_err_with_ack: assert property (p_err_with_ack)
        else $error("error pulse without acknowledge");

    property p_mask_write_ok;
        (host_cs && host_wr && host_addr == `RFS_ADDR_MASK)
            |=> host_ack_ff && !host_err_ff && ref_check_mask_ff == $past(host_wdata);
    endproperty
    a_mask_write_ok: assert property (p_mask_write_ok)
        else $error("mask write not taken");

    property p_read_mask_data;
        (host_cs && !host_wr && host_addr == `RFS_ADDR_MASK)
            |=> host_ack_ff && !host_err_ff && host_rdata_ff == $past(ref_check_mask_ff);
    endproperty
    a_read_mask_data: assert property (p_read_mask_data)
        else $error("mask read returned wrong data");

    property p_unmapped_read;
        (host_cs && !host_wr && host_addr != `RFS_ADDR_STATUS && host_addr != `RFS_ADDR_MASK)
            |=> host_err_ff && host_rdata_ff == `RFS_UNMAPPED_DATA;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not refused");

    property p_write_elsewhere_refused;
        (host_cs && host_wr && host_addr != `RFS_ADDR_MASK)
            |=> host_err_ff && $stable(ref_check_mask_ff);
    endproperty
    a_write_elsewhere_refused: assert property (p_write_elsewhere_refused)
        else $error("write outside the mask register was taken");

    property p_mask_holds;
        !(host_cs && host_wr && host_addr == `RFS_ADDR_MASK) |=> $stable(ref_check_mask_ff);
    endproperty
    a_mask_holds: assert property (p_mask_holds)
        else $error("mask changed without a mask write");

    property p_rdata_holds;
        !(host_cs && !host_wr) |=> $stable(host_rdata_ff);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data changed without a read");

    c_mask_write: cover property (
        host_cs && host_wr && host_addr == `RFS_ADDR_MASK ##1 ref_check_mask_ff != '0);
    c_status_read_fail: cover property (
        host_cs && !host_wr && host_addr == `RFS_ADDR_STATUS ##1 host_rdata_ff != '0);
    c_masked_failure: cover property (
        (ref_check_fail & ref_check_mask_ff) != '0);
    c_flag_clears: cover property (
        ref_fail_status_ff[0] ##1 !ref_fail_status_ff[0]);

endmodule : rfs_ref_fail_status_mask

// ==== rfs_ref_fail_status_mask_test.sv ====
// Purpose: self-checking bench of the reference fail status and mask block
// Assumes: inputs driven on the falling edge of sys_clk
// Notes:   one task per scenario; host reads and writes through access
`include "rfs_consts.svh"

module rfs_ref_fail_status_mask_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, arst_n, host_cs, host_wr, host_ack_ff, host_err_ff, er;
    logic [15:0] host_addr, host_wdata, fail_cmd, ref_check_fail, host_rdata_ff, rd;
    logic [15:0] ref_fail_status_ff, ref_check_mask_ff;
    int          fails, samples_checked, cycles;

    rfs_ref_source src (
        .sys_clk        (sys_clk),
        .fail_cmd       (fail_cmd),
        .ref_check_fail (ref_check_fail)
    );

    rfs_ref_fail_status_mask dut (
        .sys_clk            (sys_clk),
        .arst_n             (arst_n),
        .ref_check_fail     (ref_check_fail),
        .host_cs            (host_cs),
        .host_wr            (host_wr),
        .host_addr          (host_addr),
        .host_wdata         (host_wdata),
        .host_rdata_ff      (host_rdata_ff),
        .host_ack_ff        (host_ack_ff),
        .host_err_ff        (host_err_ff),
        .ref_fail_status_ff (ref_fail_status_ff),
        .ref_check_mask_ff  (ref_check_mask_ff)
    );

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one host access, answer captured in rd and er
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wd);
        int n;
        @(negedge sys_clk);
        host_cs = 1'b1;
        host_wr = wr;
        host_addr = addr;
        host_wdata = wd;
        @(negedge sys_clk);
        host_cs = 1'b0;
        n = 0;
        while (host_ack_ff !== 1'b1 && n < 3) begin
            @(negedge sys_clk);
            n++;
        end
        check("ack", 16'h0001, {15'h0000, host_ack_ff});
        rd = host_rdata_ff;
        er = host_err_ff;
    endtask : access

    task automatic t_reset;
        access(1'b0, `RFS_ADDR_MASK, 16'h0000);
        check("mask reset", 16'h0000, rd);
        access(1'b0, `RFS_ADDR_STATUS, 16'h0000);
        check("status idle", 16'h0000, rd);
        $display("test reset done");
    endtask : t_reset

    task automatic t_status_bits;
        for (int i = 0; i < 16; i++) begin
            fail_cmd = 16'h0001 << i;
            repeat (3) @(negedge sys_clk);
            access(1'b0, `RFS_ADDR_STATUS, 16'h0000);
            check("status bit", 16'h0001 << i, rd);
            check("status port", 16'h0001 << i, ref_fail_status_ff);
        end
        fail_cmd = 16'h0000;
        repeat (3) @(negedge sys_clk);
        access(1'b0, `RFS_ADDR_STATUS, 16'h0000);
        check("status cleared", 16'h0000, rd);
        $display("test status bits done");
    endtask : t_status_bits

    task automatic t_mask_bits;
        fail_cmd = 16'hFFFF;
        for (int i = 0; i < 16; i++) begin
            access(1'b1, `RFS_ADDR_MASK, 16'h0001 << i);
            check("mask write err", 16'h0000, {15'h0000, er});
            repeat (2) @(negedge sys_clk);
            check("mask port", 16'h0001 << i, ref_check_mask_ff);
            access(1'b0, `RFS_ADDR_STATUS, 16'h0000);
            check("masked status", ~(16'h0001 << i), rd);
            access(1'b0, `RFS_ADDR_MASK, 16'h0000);
            check("mask readback", 16'h0001 << i, rd);
        end
        access(1'b1, `RFS_ADDR_MASK, 16'h0000);
        $display("test mask bits done");
    endtask : t_mask_bits

    task automatic t_refused;
        fail_cmd = 16'h0009;
        repeat (3) @(negedge sys_clk);
        access(1'b1, `RFS_ADDR_STATUS, 16'hFFFF);
        check("status write err", 16'h0001, {15'h0000, er});
        access(1'b0, `RFS_ADDR_STATUS, 16'h0000);
        check("status after write", 16'h0009, rd);
        access(1'b0, 16'h0000, 16'h0000);
        check("unmapped data", 16'h0000, rd);
        check("unmapped err", 16'h0001, {15'h0000, er});
        $display("test refused done");
    endtask : t_refused

    task automatic t_group_mask_reset;
        fail_cmd = 16'hFFFF;
        access(1'b1, `RFS_ADDR_MASK, 16'hFFFF);
        check("full mask err", 16'h0000, {15'h0000, er});
        repeat (2) @(negedge sys_clk);
        check("full mask port", 16'hFFFF, ref_check_mask_ff);
        access(1'b0, `RFS_ADDR_STATUS, 16'h0000);
        check("all masked", 16'h0000, rd);
        arst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("reset mask port", 16'h0000, ref_check_mask_ff);
        check("reset status port", 16'h0000, ref_fail_status_ff);
        arst_n = 1'b1;
        access(1'b0, `RFS_ADDR_MASK, 16'h0000);
        check("mask after reset", 16'h0000, rd);
        access(1'b0, `RFS_ADDR_STATUS, 16'h0000);
        check("status after reset", 16'hFFFF, rd);
        fail_cmd = 16'h0000;
        $display("test group mask and reset done");
    endtask : t_group_mask_reset

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        arst_n = 1'b0;
        host_cs = 1'b0;
        host_wr = 1'b0;
        host_addr = 16'h0000;
        host_wdata = 16'h0000;
        fail_cmd = 16'h0000;
        repeat (3) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
        t_status_bits();
        t_mask_bits();
        t_refused();
        t_group_mask_reset();
        report_and_stop();
    end
endmodule : rfs_ref_fail_status_mask_test

// ==== rfs_ref_slice.sv ====
// Purpose: fail flags of one timing reference, gated by its four mask bits
// Assumes: check results are synchronous to sys_clk
// Notes:   bit order single high, single low, multi high, multi low
`include "rfs_consts.svh"

module rfs_ref_slice (
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic [`RFS_GROUP_W-1:0] check_fail,
    input  wire logic [`RFS_GROUP_W-1:0] check_mask,
    output logic      [`RFS_GROUP_W-1:0] fail_flags_ff
);

    logic [`RFS_GROUP_W-1:0] nxt_fail_flags;

    // mask forces pass; flag tracks the live outcome
    always_comb begin
        nxt_fail_flags = check_fail & ~check_mask;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fail_flags_ff <= '0;
        end else begin
            fail_flags_ff <= nxt_fail_flags;
        end
    end

    default clocking cb_slice @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    property p_slice_masked_pass;
        (check_mask != '0) |=> ((fail_flags_ff & $past(check_mask)) == '0);
    endproperty
    a_slice_masked_pass: assert property (p_slice_masked_pass)
        else $error("masked check reported a failure");

endmodule : rfs_ref_slice

// ==== rfs_ref_source.sv ====
// Purpose: model of four timing reference sources and their check outcomes
// Assumes: outcome pattern set by the bench, bit 4k+n for reference k
// Notes:   outcomes change on the falling edge, away from the sampling edge
module rfs_ref_source (
    input  wire logic        sys_clk,
    input  wire logic [15:0] fail_cmd,
    output logic      [15:0] ref_check_fail
);
    timeunit 1ns;
    timeprecision 1ps;

    // live, non-sticky outcome of each check
    always @(negedge sys_clk) begin
        ref_check_fail <= fail_cmd;
    end
endmodule : rfs_ref_source
